// >>> spi_flash_params.svh
// Constants for the serial flash instruction decoder and status register
// ============================================================
`ifndef SPI_FLASH_PARAMS_SVH
`define SPI_FLASH_PARAMS_SVH
`define READ_ARRAY_CMD 8'h03
`define BYTE_PROGRAM_CMD 8'h02
`define AUTO_PROGRAM_CMD 8'hAF
`define SECTOR_ERASE_CMD 8'h20
`define BLOCK_ERASE_CMD 8'h52
`define FULL_ERASE_CMD 8'h60
`define STATUS_READ_CMD 8'h05
`define STATUS_WRITE_ENABLE_CMD 8'h50
`define STATUS_WRITE_CMD 8'h01
`define WRITE_ENABLE_CMD 8'h06
`define WRITE_DISABLE_CMD 8'h04
`define READ_ID_CMD 8'h90
`define READ_ID_ALT_CMD 8'hAB
`define ST_BUSY 0
`define ST_WRITE_LATCH 1
`define ST_PROTECT_LO 2
`define ST_PROTECT_HI 3
`define ST_AUTO_INC 6
`define ST_LOCK 7
`define PROTECT_RESET 2'h3
`define ADDR_W 18
`define TOP_ADDR 18'h3FFFF
`define QUARTER_BASE 18'h30000
`define HALF_BASE 18'h20000
`define FIFO_DEPTH 16
`define FIFO_W 28
`define KIND_PROG 2'h0
`define KIND_SECTOR 2'h1
`define KIND_BLOCK 2'h2
`define KIND_FULL 2'h3
`endif

// >>> spi_flash_pkg.sv
// Types shared by the serial flash decoder
`default_nettype none
`include "spi_flash_params.svh"
package spi_flash_pkg;
  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_CMD = 7'h02,
    ST_ADDR = 7'h04,
    ST_DATA = 7'h08,
    ST_OUT = 7'h10,
    ST_DONE = 7'h20,
    ST_DROP = 7'h40
  } frame_state_e;
  typedef enum logic [1:0] {
    KIND_PROG = `KIND_PROG,
    KIND_SECTOR = `KIND_SECTOR,
    KIND_BLOCK = `KIND_BLOCK,
    KIND_FULL = `KIND_FULL
  } op_kind_e;
endpackage : spi_flash_pkg
`default_nettype wire

// >>> pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level
);
  logic [W-1:0] s1_q, s2_q, s3_q, level_q;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
      level_q <= INIT;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // A change counts only once stages two and three agree
      level_q <= (s2_q & s3_q) | (level_q & (s2_q ^ s3_q));
    end
  end
  assign level = level_q;
endmodule : pin_sync
`default_nettype wire

// >>> sync_fifo.sv
// Flip-flop FIFO with a registered output stage
`timescale 1ns/100ps
`default_nettype none
module sync_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic empty
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic out_valid_q;
  logic [WIDTH-1:0] out_data_q;
  logic mem_empty, full, push, pop;
  assign mem_empty = wr_q == rd_q;
  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign push = in_valid && !full;
  assign pop = !mem_empty && (!out_valid_q || out_ready);
  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
  // Output stage keeps the drain-side data straight from a flop
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_data_q <= '0;
    end else if (pop) begin
      out_valid_q <= 1'b1;
      out_data_q <= mem_q[rd_q[AW-1:0]];
    end else if (out_ready) begin
      out_valid_q <= 1'b0;
    end
  end
  assign in_ready = !full;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign empty = mem_empty && !out_valid_q;
endmodule : sync_fifo
`default_nettype wire

// >>> spi_flash_ctrl.sv
// Serial flash instruction decoder, status register and write queue
`timescale 1ns/100ps
`default_nettype none
`include "spi_flash_params.svh"
module spi_flash_ctrl import spi_flash_pkg::*; #(
  parameter logic [7:0] MFR_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] DEV_ID = 8'hC3  // Arbitrary value
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic wp_n,
  output logic so,
  output logic so_oe,
  output logic [`ADDR_W-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic prog_valid,
  input wire logic prog_ready,
  output logic [1:0] prog_kind,
  output logic [`ADDR_W-1:0] prog_addr,
  output logic [7:0] prog_data,
  input wire logic array_busy
);
  // ============================================================
  // Pin sampling
  logic [3:0] pins_s;
  logic cs_s, sck_s, si_s, wp_s;
  logic cs_prev_q, sck_prev_q;
  logic sck_rise, sck_fall, cs_fall, cs_rise;

  pin_sync #(.W(4), .INIT(4'hB)) u_sync (
    .clock(clock),
    .rst(rst),
    .pin({wp_n, si, sck, cs_n}),
    .level(pins_s)
  );
  assign cs_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign si_s = pins_s[2];
  assign wp_s = pins_s[3];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cs_prev_q <= 1'b1;
      sck_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_s;
      sck_prev_q <= sck_s;
    end
  end
  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  assign cs_fall = !cs_s && cs_prev_q;
  assign cs_rise = cs_s && !cs_prev_q;

  // ============================================================
  // Decode helpers
  function automatic frame_state_e after_opcode(input logic [7:0] op, input logic auto_on);
    case (op)
      `READ_ARRAY_CMD, `BYTE_PROGRAM_CMD, `SECTOR_ERASE_CMD, `BLOCK_ERASE_CMD,
      `READ_ID_CMD, `READ_ID_ALT_CMD: after_opcode = ST_ADDR;
      `AUTO_PROGRAM_CMD: after_opcode = auto_on ? ST_DATA : ST_ADDR;
      `STATUS_WRITE_CMD: after_opcode = ST_DATA;
      `STATUS_READ_CMD: after_opcode = ST_OUT;
      `FULL_ERASE_CMD, `WRITE_ENABLE_CMD, `WRITE_DISABLE_CMD,
      `STATUS_WRITE_ENABLE_CMD: after_opcode = ST_DONE;
      default: after_opcode = ST_DROP;
    endcase
  endfunction : after_opcode

  function automatic frame_state_e after_addr(input logic [7:0] op);
    case (op)
      `READ_ARRAY_CMD, `READ_ID_CMD, `READ_ID_ALT_CMD: after_addr = ST_OUT;
      `BYTE_PROGRAM_CMD, `AUTO_PROGRAM_CMD: after_addr = ST_DATA;
      default: after_addr = ST_DONE;
    endcase
  endfunction : after_addr

  function automatic logic in_protected(input logic [`ADDR_W-1:0] a, input logic [1:0] level);
    case (level)
      2'h1: in_protected = a >= `QUARTER_BASE;
      2'h2: in_protected = a >= `HALF_BASE;
      2'h3: in_protected = 1'b1;
      default: in_protected = 1'b0;
    endcase
  endfunction : in_protected

  // ============================================================
  // Instruction framing
  frame_state_e state_q;
  logic [2:0] bit_cnt_q;
  logic [1:0] byte_cnt_q;
  logic [7:0] shift_q, opcode_q, data_q;
  logic [23:0] addr_q;
  logic [7:0] rx_byte;
  logic in_byte;
  logic auto_increment_program_q;

  assign rx_byte = {shift_q[6:0], si_s};
  assign in_byte = (state_q == ST_CMD) || (state_q == ST_ADDR) || (state_q == ST_DATA);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_IDLE;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 2'h0;
      shift_q <= 8'h00;
      opcode_q <= 8'h00;
      addr_q <= 24'h000000;
      data_q <= 8'h00;
    end else if (cs_rise) begin
      state_q <= ST_IDLE;
    end else if (cs_fall) begin
      state_q <= ST_CMD;
      bit_cnt_q <= 3'h0;
      byte_cnt_q <= 2'h0;
    end else if (sck_rise && in_byte) begin
      shift_q <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (bit_cnt_q == 3'h7) begin
        case (state_q)
          ST_CMD: begin
            opcode_q <= rx_byte;
            state_q <= after_opcode(rx_byte, auto_increment_program_q);
          end
          ST_ADDR: begin
            addr_q <= {addr_q[15:0], rx_byte};
            byte_cnt_q <= byte_cnt_q + 2'h1;
            if (byte_cnt_q == 2'h2) begin
              state_q <= after_addr(opcode_q);
            end
          end
          ST_DATA: begin
            data_q <= rx_byte;
            state_q <= ST_DONE;
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // ============================================================
  // Status register and command execution
  logic write_latch_flag_q, protect_lock_flag_q, busy_q, arm_status_q;
  logic [1:0] protect_level_q;
  logic [`ADDR_W-1:0] auto_addr_q, target_addr;
  logic [7:0] status_byte;
  logic exec, write_op, accept, auto_last, pend_q;
  logic [1:0] pend_kind_q;
  logic [`ADDR_W-1:0] pend_addr_q;
  logic [7:0] pend_data_q;
  logic fifo_in_ready, fifo_empty;

  // Execution happens only at deselect of a complete instruction
  assign exec = cs_rise && (state_q == ST_DONE);
  assign write_op = (opcode_q == `BYTE_PROGRAM_CMD) || (opcode_q == `AUTO_PROGRAM_CMD) ||
                    (opcode_q == `SECTOR_ERASE_CMD) || (opcode_q == `BLOCK_ERASE_CMD) ||
                    (opcode_q == `FULL_ERASE_CMD);
  assign target_addr = ((opcode_q == `AUTO_PROGRAM_CMD) && auto_increment_program_q) ?
                       auto_addr_q : addr_q[`ADDR_W-1:0];
  assign accept = exec && write_op && write_latch_flag_q && !busy_q && !pend_q &&
                  ((opcode_q == `FULL_ERASE_CMD) ? (protect_level_q == 2'h0) :
                   !in_protected(target_addr, protect_level_q));
  // Auto-increment stops at the top or at the last address below the first protected one
  assign auto_last = (target_addr == `TOP_ADDR) ||
                     in_protected(target_addr + `ADDR_W'(1), protect_level_q);

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_latch_flag_q <= 1'b0;
    end else if (exec && (opcode_q == `WRITE_ENABLE_CMD)) begin
      write_latch_flag_q <= 1'b1;
    end else if (exec && (opcode_q == `WRITE_DISABLE_CMD)) begin
      write_latch_flag_q <= 1'b0;
    end else if (accept && ((opcode_q != `AUTO_PROGRAM_CMD) || auto_last)) begin
      write_latch_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      auto_increment_program_q <= 1'b0;
      auto_addr_q <= '0;
    end else if ((exec && (opcode_q == `WRITE_DISABLE_CMD)) ||
                 (accept && (opcode_q != `AUTO_PROGRAM_CMD))) begin
      auto_increment_program_q <= 1'b0;
    end else if (accept && (opcode_q == `AUTO_PROGRAM_CMD)) begin
      auto_increment_program_q <= !auto_last;
      auto_addr_q <= target_addr + `ADDR_W'(1);
    end
  end

  // Any instruction after the arming one disarms it, aborted or not
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      arm_status_q <= 1'b0;
    end else if (cs_rise) begin
      arm_status_q <= exec && (opcode_q == `STATUS_WRITE_ENABLE_CMD);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      protect_level_q <= `PROTECT_RESET;
      protect_lock_flag_q <= 1'b0;
    end else if (exec && (opcode_q == `STATUS_WRITE_CMD) && arm_status_q &&
                 (wp_s || !protect_lock_flag_q)) begin
      protect_level_q <= {data_q[`ST_PROTECT_HI], data_q[`ST_PROTECT_LO]};
      protect_lock_flag_q <= data_q[`ST_LOCK];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= array_busy || pend_q || !fifo_empty;
    end
  end

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ST_BUSY] = busy_q;
    status_byte[`ST_WRITE_LATCH] = write_latch_flag_q;
    status_byte[`ST_PROTECT_LO] = protect_level_q[0];
    status_byte[`ST_PROTECT_HI] = protect_level_q[1];
    status_byte[`ST_AUTO_INC] = auto_increment_program_q;
    status_byte[`ST_LOCK] = protect_lock_flag_q;
  end

  // ============================================================
  // Write queue toward the array; a full queue holds the request and reads as busy
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pend_q <= 1'b0;
      pend_kind_q <= `KIND_PROG;
      pend_addr_q <= '0;
      pend_data_q <= 8'h00;
    end else if (accept) begin
      pend_q <= 1'b1;
      pend_addr_q <= target_addr;
      pend_data_q <= data_q;
      case (opcode_q)
        `SECTOR_ERASE_CMD: pend_kind_q <= `KIND_SECTOR;
        `BLOCK_ERASE_CMD: pend_kind_q <= `KIND_BLOCK;
        `FULL_ERASE_CMD: pend_kind_q <= `KIND_FULL;
        default: pend_kind_q <= `KIND_PROG;
      endcase
    end else if (pend_q && fifo_in_ready) begin
      pend_q <= 1'b0;
    end
  end

  sync_fifo #(.WIDTH(`FIFO_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst(rst),
    .in_valid(pend_q),
    .in_ready(fifo_in_ready),
    .in_data({pend_kind_q, pend_addr_q, pend_data_q}),
    .out_valid(prog_valid),
    .out_ready(prog_ready),
    .out_data({prog_kind, prog_addr, prog_data}),
    .empty(fifo_empty)
  );

  // ============================================================
  // Serial output
  logic out_prev_q, need_q, so_q, so_oe_q, load_now;
  logic [7:0] out_sh_q, src_byte;
  logic [2:0] out_cnt_q;
  logic [`ADDR_W-1:0] rd_addr_q;

  // Load waits one cycle so the read pointer has taken the new address
  assign load_now = (state_q == ST_OUT) && out_prev_q && need_q;
  always_comb begin
    if (opcode_q == `STATUS_READ_CMD) begin
      src_byte = status_byte;
    end else if (opcode_q == `READ_ARRAY_CMD) begin
      src_byte = rd_data;
    end else begin
      src_byte = addr_q[0] ? DEV_ID : MFR_ID;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      out_prev_q <= 1'b0;
      need_q <= 1'b1;
      out_sh_q <= 8'h00;
      out_cnt_q <= 3'h0;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      out_prev_q <= state_q == ST_OUT;
      if (state_q != ST_OUT) begin
        need_q <= 1'b1;
        out_cnt_q <= 3'h0;
        so_q <= 1'b0;
        so_oe_q <= 1'b0;
      end else if (load_now) begin
        out_sh_q <= src_byte;
        need_q <= 1'b0;
      end else if (sck_fall) begin
        so_q <= out_sh_q[7];
        so_oe_q <= 1'b1;
        out_sh_q <= {out_sh_q[6:0], 1'b0};
        out_cnt_q <= out_cnt_q + 3'h1;
        if (out_cnt_q == 3'h7) begin
          need_q <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rd_addr_q <= '0;
    end else if (!out_prev_q) begin
      rd_addr_q <= addr_q[`ADDR_W-1:0];
    end else if (load_now && (opcode_q == `READ_ARRAY_CMD)) begin
      rd_addr_q <= rd_addr_q + `ADDR_W'(1);
    end
  end

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign rd_addr = rd_addr_q;

  // ============================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  busy_follows_a: assert property (pend_q |=> busy_q)
    else $error("busy not shown while a write is pending");
  latch_guard_a: assert property ($rose(pend_q) |-> $past(write_latch_flag_q))
    else $error("write queued without write latch");
  latch_clear_a: assert property (exec && (opcode_q == `WRITE_DISABLE_CMD) |=> !write_latch_flag_q)
    else $error("write latch survived write-disable");
  area_block_a: assert property ($rose(pend_q) && (pend_kind_q != `KIND_FULL) |->
                                 !in_protected(pend_addr_q, protect_level_q))
    else $error("write queued into protected area");
  full_erase_a: assert property ($rose(pend_q) && (pend_kind_q == `KIND_FULL) |-> protect_level_q == 2'h0)
    else $error("full erase queued while protected");
  lock_hold_a: assert property (!wp_s && protect_lock_flag_q |=>
                                protect_lock_flag_q && $stable(protect_level_q))
    else $error("locked protection bits changed");
  unarmed_write_a: assert property (exec && (opcode_q == `STATUS_WRITE_CMD) && !arm_status_q |=>
                                    $stable(protect_level_q))
    else $error("status write acted without arming");
  abort_quiet_a: assert property (cs_rise && (state_q != ST_DONE) |=>
                                  $stable(write_latch_flag_q) && !$rose(pend_q))
    else $error("aborted instruction had an effect");
  frame_start_a: assert property (cs_fall && !cs_rise |=> (state_q == ST_CMD) && (bit_cnt_q == 3'h0))
    else $error("decode did not restart at select");
  auto_mode_a: assert property (auto_increment_program_q |-> write_latch_flag_q)
    else $error("auto-increment mode without write latch");
  drive_scope_a: assert property (so_oe_q |-> $past(state_q == ST_OUT))
    else $error("serial output driven outside an output phase");
  reserved_zero_a: assert property (load_now && (opcode_q == `STATUS_READ_CMD) |=> out_sh_q[5:4] == 2'h0)
    else $error("reserved status bits not zero");
endmodule : spi_flash_ctrl
`default_nettype wire

// >>> spi_host_model.sv
// Serial host model driving chip select, clock and data in mode 3
`timescale 1ns/100ps
`default_nettype none
module spi_host_model (
  input wire logic clock,
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    si = 1'b0;
  end

  task automatic half;
    repeat (4) @(posedge clock);
  endtask : half

  // ============================================================
  // One framed instruction
  // Sends n_out bits MSB first, then clocks n_in bits back.
  // So is taken at the end of the high phase, because the device
  // only moves it several system clocks after seeing the fall.
  task automatic frame(input logic [39:0] tx, input int n_out, input int n_in, output logic [15:0] rx);
    int i;
    cs_n <= 1'b0;
    half();
    for (i = 0; i < n_out + n_in; i++) begin
      sck <= 1'b0;
      si <= (i < n_out) ? tx[n_out - 1 - i] : ~si;
      half();
      sck <= 1'b1;
      half();
      if (i >= n_out) begin
        rx = {rx[14:0], so};
      end
    end
    cs_n <= 1'b1;
    si <= ~si;
    repeat (6) @(posedge clock);
  endtask : frame
endmodule : spi_host_model
`default_nettype wire

// >>> testbench.sv
// Self-checking bench for the serial flash decoder
`timescale 1ns/100ps
`default_nettype none
`include "spi_flash_params.svh"
module testbench;
  localparam logic [7:0] MFR = 8'h3C; // Arbitrary value
  localparam logic [7:0] DEV = 8'h96; // Arbitrary value
  logic clock, rst, wp_n, prog_ready, array_busy, cs_n, sck, si, so, so_oe, prog_valid;
  logic [`ADDR_W-1:0] rd_addr, prog_addr;
  logic [7:0] rd_data, prog_data;
  logic [1:0] prog_kind;
  logic [15:0] rx;
  logic oe_seen;
  int n_fail = 0;
  int compares = 0;
  int cycles = 0;

  // Array model: low address byte with the top two address bits folded in
  assign rd_data = rd_addr[7:0] ^ {6'h00, rd_addr[17:16]};

  spi_flash_ctrl #(.MFR_ID(MFR), .DEV_ID(DEV)) i_spi_flash_ctrl (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .so(so), .so_oe(so_oe),
    .rd_addr(rd_addr), .rd_data(rd_data), .prog_valid(prog_valid), .prog_ready(prog_ready),
    .prog_kind(prog_kind), .prog_addr(prog_addr), .prog_data(prog_data), .array_busy(array_busy)
  );

  spi_host_model host (.clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .so(so));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // Remembers whether the output was driven in the last framed instruction
  always @(posedge clock) begin
    oe_seen <= so_oe ? 1'b1 : (cs_n ? oe_seen : 1'b0);
  end

  // ============================================================
  // Helpers
  task automatic end_of_test;
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic check(input logic [27:0] got, input logic [27:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic send(input logic [39:0] tx, input int nb);
    host.frame(tx, nb * 8, 0, rx);
  endtask : send

  // Two status bytes back to back must both match
  task automatic status(input logic [7:0] exp);
    host.frame(40'h05, 8, 16, rx);
    check({12'h000, rx}, {12'h000, exp, exp});
    // The enable drops two clocks after the deselect is seen
    @(posedge clock);
    check({26'h0, oe_seen, so_oe}, 28'h0000002);
  endtask : status

  task automatic wsr(input logic [7:0] v);
    send(40'h50, 1);
    send({24'h000000, 8'h01, v}, 2);
  endtask : wsr

  task automatic pop(input logic [27:0] exp, input logic [27:0] mask);
    int i;
    for (i = 0; i < 40 && prog_valid !== 1'b1; i++) @(posedge clock);
    check({prog_kind, prog_addr, prog_data} & mask, exp);
    prog_ready <= 1'b1;
    @(posedge clock);
    prog_ready <= 1'b0;
  endtask : pop

  task automatic none_queued;
    repeat (8) @(posedge clock);
    check({27'h0000000, prog_valid}, 28'h0000000);
  endtask : none_queued

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ============================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    wp_n = 1'b1;
    prog_ready = 1'b0;
    array_busy = 1'b0;
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (6) @(posedge clock);
    status(8'h0C);
    host.frame(40'h90000000, 32, 8, rx);
    check({20'h00000, rx[7:0]}, {20'h00000, MFR});
    host.frame(40'hAB000001, 32, 16, rx);
    check({12'h000, rx}, {12'h000, DEV, DEV});
    host.frame(40'h03FFFFFF, 32, 16, rx);
    check({12'h000, rx}, 28'h000FC00);
    send(40'h06, 1);
    status(8'h0E);
    send({8'h02, 24'h3FFFFF, 8'h11}, 5);
    none_queued();
    send(40'h04, 1);
    status(8'h0C);
    send(40'h0100, 2);
    status(8'h0C);
    wsr(8'hF4);
    status(8'h84);
    wp_n <= 1'b0;
    wsr(8'h00);
    status(8'h84);
    wp_n <= 1'b1;
    wsr(8'h04);
    status(8'h04);
    send(40'h06, 1);
    send({8'h02, 24'h030000, 8'h11}, 5);
    none_queued();
    send(40'h60, 1);
    none_queued();
    send({8'h02, 24'hFEFFFF, 8'hA7}, 5);
    status(8'h05);
    pop({2'h0, 18'h2FFFF, 8'hA7}, 28'hFFFFFFF);
    wsr(8'h00);
    send({8'h02, 24'h001000, 8'h11}, 5);
    none_queued();
    send(40'h06, 1);
    send({8'h20, 24'h012345}, 4);
    pop({2'h1, 18'h12345, 8'h00}, 28'hFFFFF00);
    send(40'h06, 1);
    send({8'h52, 24'h023456}, 4);
    pop({2'h2, 18'h23456, 8'h00}, 28'hFFFFF00);
    send(40'h06, 1);
    send(40'h60, 1);
    pop({2'h3, 26'h0000000}, 28'hC000000);
    status(8'h00);
    wsr(8'h04);
    send(40'h06, 1);
    send({8'hAF, 24'h02FFFE, 8'hD0}, 5);
    pop({2'h0, 18'h2FFFE, 8'hD0}, 28'hFFFFFFF);
    status(8'h46);
    send(40'hAFD1, 2);
    pop({2'h0, 18'h2FFFF, 8'hD1}, 28'hFFFFFFF);
    status(8'h04);
    wsr(8'h00);
    host.frame(40'h03, 7, 0, rx);
    status(8'h00);
    array_busy <= 1'b1;
    status(8'h01);
    array_busy <= 1'b0;
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
